// >>> inc/sctm_pkg.sv
// Purpose: shared constants and types of the smart card timer 0 block
// Assumes: 32-bit Avalon-MM register slave, byte addresses
// Notes: counter width is fixed here because the state struct needs it
package sctm_pkg;

	// register byte offsets
	localparam logic [4:0] SCTM_OFF_CTRL = 5'h00;
	localparam logic [4:0] SCTM_OFF_RELOAD = 5'h04;
	localparam logic [4:0] SCTM_OFF_RESULT = 5'h08;
	localparam logic [4:0] SCTM_OFF_STATUS = 5'h0c;
	localparam logic [4:0] SCTM_OFF_CLEAR = 5'h10;
	localparam logic [4:0] SCTM_OFF_IRQ_EN = 5'h14;
	localparam logic [4:0] SCTM_OFF_COUNT = 5'h18;

	// field positions
	localparam int SCTM_CTRL_RUN_BIT = 0;
	localparam int SCTM_CTRL_LIVE_BIT = 1;
	localparam int SCTM_CTRL_MODE_LSB = 4;
	localparam int SCTM_STAT_TMO_BIT = 0;
	localparam int SCTM_STAT_BUSY_BIT = 1;

	localparam int SCTM_CNT_W = 24;

	// mode encodings
	localparam logic [3:0] SCTM_MODE_FREE_ONCE = 4'h0;
	localparam logic [3:0] SCTM_MODE_ANY_ONCE = 4'h1;
	localparam logic [3:0] SCTM_MODE_RX_ONCE = 4'h2;
	localparam logic [3:0] SCTM_MODE_ATR = 4'h3;
	localparam logic [3:0] SCTM_MODE_FREE_LOOP = 4'h4;
	localparam logic [3:0] SCTM_MODE_ANY_LOOP = 4'h5;
	localparam logic [3:0] SCTM_MODE_RX_LOOP = 4'h6;
	localparam logic [3:0] SCTM_MODE_GAP = 4'h7;
	localparam logic [3:0] SCTM_MODE_UP = 4'h8;

	// values after reset, and the start value of the up count
	localparam logic [3:0] SCTM_RST_MODE = 4'h0;
	localparam logic [SCTM_CNT_W-1:0] SCTM_RST_CNT = 24'h000000;
	localparam logic [SCTM_CNT_W-1:0] SCTM_UP_PRESET = 24'hffffff;
	localparam logic [31:0] SCTM_RST_RDATA = 32'h00000000;

	typedef enum logic [1:0] {
		SCTM_IDLE,
		SCTM_WAIT_START,
		SCTM_WAIT_RST,
		SCTM_COUNT
	} sctm_phase_e;

	// card side events, all one-cycle pulses, reset release included
	typedef struct packed {
		logic rx_start;
		logic tx_start;
		logic atr;
		logic tick;
		logic rst_rel;
	} sctm_evt_s;

	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic run_en;
		logic live;
		logic [3:0] mode;
		logic [SCTM_CNT_W-1:0] reload;
		logic [SCTM_CNT_W-1:0] shadow;
		logic [SCTM_CNT_W-1:0] cnt;
		logic [SCTM_CNT_W-1:0] result;
		sctm_phase_e phase;
		logic tmo_flag;
		logic tmo_en;
		logic irq;
		logic rst_prev;
	} sctm_state_s;

	localparam sctm_state_s SCTM_STATE_RST = '{
		waitreq: 1'b1,
		rdata: SCTM_RST_RDATA,
		run_en: 1'b0,
		live: 1'b0,
		mode: SCTM_RST_MODE,
		reload: SCTM_RST_CNT,
		shadow: SCTM_RST_CNT,
		cnt: SCTM_RST_CNT,
		result: SCTM_RST_CNT,
		phase: SCTM_IDLE,
		tmo_flag: 1'b0,
		tmo_en: 1'b0,
		irq: 1'b0,
		rst_prev: 1'b0
	};

endpackage : sctm_pkg

// >>> rtl/sctm_sync.sv
// Purpose: two-flop synchroniser for levels from pins
// Assumes: destination clock is clk_in
// Notes: first stage feeds only the second stage
module sctm_sync
	import sctm_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_in, // destination clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic [W-1:0] d_in, // asynchronous level
	output logic [W-1:0] q_out // synchronised level
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end

endmodule : sctm_sync

// >>> rtl/sctm_timer0.sv
// Purpose: timer channel 0 of a smart card host, modes 0 to 8
// Assumes: start, answer and tick pulses come from logic on clk_in
// Notes: card reset line arrives from a pin and is synchronised here
//
// Contract
// R1 - Mode 3 counts from card reset release once run enable is set.
// R2 - Mode 3 zero before the answer sets the flag, clears run enable.
// R3 - Mode 3 answer at nonzero count clears run enable, no flag.
// R4 - Software uses mode 3 only during card activation or warm reset.
// R5 - Mode 4 counts at once; at zero sets the flag, reloads, goes on.
// R6 - With live reload on, the newest count is loaded at the next zero.
// R7 - Every down count times out after the programmed count plus one ticks.
// R8 - Mode 5 at zero sets flag, reloads, restarts on any start bit.
// R9 - Mode 6 at zero sets flag, reloads, restarts on a received start.
// R10 - Mode 7 starts at the first start bit, runs until software stops.
// R11 - Mode 7 reloads the newest count on every further start bit; after a zero the code reloads the count held at start unless live is on.
// R12 - Mode 7 interrupts when zero comes before the next start bit.
// R13 - Mode 8 counts up into a 24-bit result, no interrupt, value plus one.
// R14 - Time-out flag stays until cleared, interrupts when enabled.
module sctm_timer0
	import sctm_pkg::*;
(
	input wire logic clk_in, // block clock, 40 MHz
	input wire logic rst_n_in, // async reset, active low
	input wire logic [4:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // write byte lanes
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall, high by default
	input wire logic card_reset_line_n_in, // card reset pin, low = reset
	input wire logic rx_start_in, // received start bit pulse
	input wire logic tx_start_in, // transmitted start bit pulse
	input wire logic atr_received_in, // answer-to-reset pulse
	input wire logic count_tick_in, // counter tick pulse
	output logic irq_out, // level interrupt
	output logic timer0_timeout_flag_out, // sticky time-out flag
	output logic timer0_run_enable_out // run enable readback
);

	sctm_state_s s_r;
	sctm_state_s s_nxt;
	sctm_evt_s evt;
	logic rst_sync;

	sctm_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_rst_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(card_reset_line_n_in),
		.q_out(rst_sync)
	);

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] sctm_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : sctm_merge

	always_comb begin
		logic req;
		logic wr;
		logic clr;
		logic hit;
		logic auto_clr;
		logic start_sel;
		logic [31:0] ctrl_word;
		logic [31:0] wmerged;
		logic [SCTM_CNT_W-1:0] reload_val;
		req = 1'b0;
		wr = 1'b0;
		clr = 1'b0;
		hit = 1'b0;
		auto_clr = 1'b0;
		start_sel = 1'b0;
		ctrl_word = 32'h00000000;
		wmerged = 32'h00000000;
		reload_val = SCTM_RST_CNT;
		s_nxt = s_r;

		evt.rx_start = rx_start_in;
		evt.tx_start = tx_start_in;
		evt.atr = atr_received_in;
		evt.tick = count_tick_in;
		// release of the card reset line is its rising edge
		evt.rst_rel = rst_sync && !s_r.rst_prev;
		s_nxt.rst_prev = rst_sync;

		ctrl_word[SCTM_CTRL_RUN_BIT] = s_r.run_en;
		ctrl_word[SCTM_CTRL_LIVE_BIT] = s_r.live;
		ctrl_word[SCTM_CTRL_MODE_LSB +: 4] = s_r.mode;

		// one wait cycle, then the access completes
		req = avs_read_in || avs_write_in;
		s_nxt.waitreq = !(req && s_r.waitreq);
		wr = avs_write_in && !s_r.waitreq;

		if (avs_read_in && s_r.waitreq) begin
			s_nxt.rdata = 32'h00000000;
			if (avs_address_in == SCTM_OFF_CTRL) begin
				s_nxt.rdata = ctrl_word;
			end else if (avs_address_in == SCTM_OFF_RELOAD) begin
				s_nxt.rdata[SCTM_CNT_W-1:0] = s_r.reload;
			end else if (avs_address_in == SCTM_OFF_RESULT) begin
				s_nxt.rdata[SCTM_CNT_W-1:0] = s_r.result;
			end else if (avs_address_in == SCTM_OFF_STATUS) begin
				s_nxt.rdata[SCTM_STAT_TMO_BIT] = s_r.tmo_flag;
				s_nxt.rdata[SCTM_STAT_BUSY_BIT] = s_r.phase == SCTM_COUNT;
			end else if (avs_address_in == SCTM_OFF_IRQ_EN) begin
				s_nxt.rdata[SCTM_STAT_TMO_BIT] = s_r.tmo_en;
			end else if (avs_address_in == SCTM_OFF_COUNT) begin
				s_nxt.rdata[SCTM_CNT_W-1:0] = s_r.cnt;
			end
		end

		// live reload takes the newest count, else the one held at start
		reload_val = s_r.live ? s_r.reload : s_r.shadow; // see R6
		if (s_r.mode == SCTM_MODE_RX_ONCE || s_r.mode == SCTM_MODE_RX_LOOP) begin
			start_sel = evt.rx_start; // see R9
		end else begin
			start_sel = evt.rx_start || evt.tx_start; // see R8
		end

		case (s_r.phase)
			SCTM_IDLE: begin
				if (s_r.run_en) begin
					s_nxt.shadow = s_r.reload;
					case (s_r.mode)
						SCTM_MODE_FREE_ONCE, SCTM_MODE_FREE_LOOP: begin
							s_nxt.phase = SCTM_COUNT; // see R5
							s_nxt.cnt = s_r.reload;
						end
						SCTM_MODE_UP: begin
							// preset so the stored value is elapsed minus one
							s_nxt.phase = SCTM_COUNT; // see R13
							s_nxt.cnt = SCTM_UP_PRESET;
						end
						SCTM_MODE_ATR: begin
							s_nxt.phase = SCTM_WAIT_RST; // see R1
						end
						SCTM_MODE_ANY_ONCE, SCTM_MODE_RX_ONCE,
						SCTM_MODE_ANY_LOOP, SCTM_MODE_RX_LOOP,
						SCTM_MODE_GAP: begin
							s_nxt.phase = SCTM_WAIT_START; // see R10
						end
						default: begin
							s_nxt.phase = SCTM_IDLE;
						end
					endcase
				end
			end
			SCTM_WAIT_START: begin
				if (start_sel) begin
					s_nxt.phase = SCTM_COUNT; // see R8
					s_nxt.cnt = reload_val;
				end
			end
			SCTM_WAIT_RST: begin
				if (evt.rst_rel) begin
					s_nxt.phase = SCTM_COUNT; // see R1
					s_nxt.cnt = reload_val;
				end
			end
			SCTM_COUNT: begin
				if (s_r.mode == SCTM_MODE_UP) begin
					if (evt.tick) begin
						s_nxt.cnt = s_r.cnt + 24'h000001; // see R13
					end
				end else if (evt.tick && s_r.cnt == SCTM_RST_CNT) begin
					// zero reached on a tick: count plus one ticks elapsed
					hit = 1'b1; // see R7
					case (s_r.mode)
						SCTM_MODE_FREE_LOOP: begin
							s_nxt.cnt = reload_val; // see R5
						end
						SCTM_MODE_ANY_LOOP, SCTM_MODE_RX_LOOP,
						SCTM_MODE_GAP: begin
							s_nxt.cnt = reload_val; // see R12
							s_nxt.phase = SCTM_WAIT_START; // see R9
						end
						default: begin
							auto_clr = 1'b1; // see R2
						end
					endcase
				end else if (s_r.mode == SCTM_MODE_ATR && evt.atr) begin
					auto_clr = 1'b1; // see R3
				end else if (s_r.mode == SCTM_MODE_GAP &&
					(evt.rx_start || evt.tx_start)) begin
					s_nxt.cnt = s_r.reload; // see R11
				end else if (evt.tick) begin
					s_nxt.cnt = s_r.cnt - 24'h000001;
				end
			end
			default: begin
				s_nxt.phase = SCTM_IDLE;
			end
		endcase

		if (auto_clr) begin
			s_nxt.run_en = 1'b0; // see R2
			s_nxt.phase = SCTM_IDLE;
		end
		if (!s_r.run_en) begin
			s_nxt.phase = SCTM_IDLE;
		end
		if (s_r.mode == SCTM_MODE_UP && s_r.phase == SCTM_COUNT) begin
			s_nxt.result = s_nxt.cnt; // see R13
		end

		// software write, taking precedence over the automatic clear
		if (wr) begin
			if (avs_address_in == SCTM_OFF_CTRL) begin
				wmerged = sctm_merge(ctrl_word, avs_writedata_in,
					avs_byteenable_in);
				s_nxt.run_en = wmerged[SCTM_CTRL_RUN_BIT];
				s_nxt.live = wmerged[SCTM_CTRL_LIVE_BIT];
				s_nxt.mode = wmerged[SCTM_CTRL_MODE_LSB +: 4];
			end else if (avs_address_in == SCTM_OFF_RELOAD) begin
				wmerged = sctm_merge({8'h00, s_r.reload}, avs_writedata_in,
					avs_byteenable_in);
				s_nxt.reload = wmerged[SCTM_CNT_W-1:0]; // see R6
			end else if (avs_address_in == SCTM_OFF_CLEAR) begin
				clr = avs_byteenable_in[0] &&
					avs_writedata_in[SCTM_STAT_TMO_BIT];
			end else if (avs_address_in == SCTM_OFF_IRQ_EN) begin
				if (avs_byteenable_in[0]) begin
					s_nxt.tmo_en = avs_writedata_in[SCTM_STAT_TMO_BIT];
				end
			end
		end

		// sticky flag, a new time-out beats a clear in the same cycle
		s_nxt.tmo_flag = (s_r.tmo_flag && !clr) || hit; // see R14
		s_nxt.irq = s_nxt.tmo_flag && s_nxt.tmo_en; // see R14
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= SCTM_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata_out = s_r.rdata;
	assign avs_waitrequest_out = s_r.waitreq;
	assign irq_out = s_r.irq;
	assign timer0_timeout_flag_out = s_r.tmo_flag;
	assign timer0_run_enable_out = s_r.run_en;

endmodule : sctm_timer0

// >>> verif/sctm_card_model.sv
// Purpose: card side stand-in: reset pin, start bits, answer, ticks
// Assumes: pulses launched by non-blocking assignment after a rising edge
// Notes: all pulses one cycle wide with a low cycle after each
module sctm_card_model (
	input wire logic clk_in, // block clock
	output logic card_reset_line_n_out, // card reset pin, low = reset
	output logic rx_start_out, // received start pulse
	output logic tx_start_out, // sent start pulse
	output logic atr_out, // answer pulse
	output logic tick_out // counter tick pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		card_reset_line_n_out = 1'b1;
		{rx_start_out, tx_start_out, atr_out, tick_out} = 4'h0;
	end
	// pin level, then settle time for the synchroniser
	task automatic rst_line(input logic v);
		@(posedge clk_in);
		card_reset_line_n_out <= v;
		repeat (4) @(posedge clk_in);
	endtask : rst_line
	// sel 0 rx, 1 tx, 2 answer, 3 tick
	task automatic pulse(input int sel, input int n);
		repeat (n) begin
			@(posedge clk_in);
			{rx_start_out, tx_start_out, atr_out, tick_out} <= 4'h8 >> sel;
			@(posedge clk_in);
			{rx_start_out, tx_start_out, atr_out, tick_out} <= 4'h0;
		end
	endtask : pulse
endmodule : sctm_card_model

// >>> verif/sctm_timer0_asserts.sv
// Purpose: port-level checks of smart card timer 0
// Assumes: mode only rewritten while the timer is idle
// Notes: mode is tracked from completed control writes
module sctm_timer0_asserts
	import sctm_pkg::*;
(
	input wire logic clk_in, // block clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic [4:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic avs_waitrequest_out, // stall
	input wire logic atr_received_in, // answer pulse
	input wire logic irq_out, // level interrupt
	input wire logic timer0_timeout_flag_out, // sticky flag
	input wire logic timer0_run_enable_out // run enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] mode_r;
	logic done;
	assign done = avs_write_in && !avs_waitrequest_out;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mode_r <= SCTM_RST_MODE;
		else if (done && avs_address_in == SCTM_OFF_CTRL)
			mode_r <= avs_writedata_in[SCTM_CTRL_MODE_LSB +: 4];
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_bus_one_wait: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("request not answered after one wait");
	a_bus_wait_back: assert property (!avs_waitrequest_out |=>
		avs_waitrequest_out) else $error("waitrequest low too long");
	a_irq_has_flag: assert property (irq_out |->
		timer0_timeout_flag_out || $past(timer0_timeout_flag_out))
		else $error("interrupt without flag");
	a_flag_held: assert property ($fell(timer0_timeout_flag_out) |->
		$past(done && avs_address_in == SCTM_OFF_CLEAR &&
		avs_writedata_in[0])) else $error("flag fell without clear");
	a_loop_keeps_run: assert property ($rose(timer0_timeout_flag_out) &&
		mode_r inside {[SCTM_MODE_FREE_LOOP:SCTM_MODE_GAP]} |->
		timer0_run_enable_out) else $error("loop mode dropped run");
	a_atr_mode_stop: assert property ($rose(timer0_timeout_flag_out) &&
		mode_r == SCTM_MODE_ATR |-> !timer0_run_enable_out)
		else $error("run kept after answer timeout");
	a_up_no_flag: assert property (mode_r == SCTM_MODE_UP |->
		!$rose(timer0_timeout_flag_out)) else $error("up count set flag");
	a_answer_stops: assert property (atr_received_in &&
		timer0_run_enable_out && mode_r == SCTM_MODE_ATR &&
		!timer0_timeout_flag_out |=> !timer0_run_enable_out &&
		!timer0_timeout_flag_out) else $error("answer did not stop run");
endmodule : sctm_timer0_asserts
bind sctm_timer0 sctm_timer0_asserts chk_u (.clk_in, .rst_n_in,
	.avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
	.avs_waitrequest_out, .atr_received_in, .irq_out,
	.timer0_timeout_flag_out, .timer0_run_enable_out);

// >>> verif/testbench.sv
// Purpose: register-level test of smart card timer 0
// Assumes: flag sampled three edges after the last tick
// Notes: byte lanes tied on, all accesses are whole words
module testbench
	import sctm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic [4:0] avs_address_in = 5'h00;
	logic [31:0] avs_writedata_in = 32'h00000000, avs_readdata_out;
	logic avs_waitrequest_out, irq_out, card_reset_line_n_in, rx_start_in;
	logic tx_start_in, atr_received_in, count_tick_in;
	logic timer0_timeout_flag_out, timer0_run_enable_out;
	int error_cnt = 0, checked = 0, cyc = 0;
	sctm_timer0 dut_u (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
		.avs_readdata_out, .avs_waitrequest_out, .card_reset_line_n_in,
		.rx_start_in, .tx_start_in, .atr_received_in, .count_tick_in,
		.irq_out, .timer0_timeout_flag_out, .timer0_run_enable_out);
	sctm_card_model card_u (.clk_in,
		.card_reset_line_n_out(card_reset_line_n_in),
		.rx_start_out(rx_start_in), .tx_start_out(tx_start_in),
		.atr_out(atr_received_in), .tick_out(count_tick_in));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	always @(posedge clk_in) begin
		cyc++;
		if (cyc > 5000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_address_in <= a;
		avs_writedata_in <= d;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : acc
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd
	task automatic tk(input int n, input logic e);
		repeat (2) @(posedge clk_in);
		card_u.pulse(3, n);
		repeat (3) @(posedge clk_in);
		chk(32'(timer0_timeout_flag_out), 32'(e));
	endtask : tk
	initial begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int a = 0; a < 32; a += 4)
			rd(5'(a), 32'h0);
		wr(5'h1c, 32'hffffffff);
		rd(5'h1c, 32'h0);
		wr(SCTM_OFF_RELOAD, 32'hff000003);
		rd(SCTM_OFF_RELOAD, 32'h3);
		wr(SCTM_OFF_IRQ_EN, 32'h1);
		rd(SCTM_OFF_IRQ_EN, 32'h1);
		wr(SCTM_OFF_CTRL, 32'h43);
		rd(SCTM_OFF_CTRL, 32'h43);
		tk(3, 1'b0);
		wr(SCTM_OFF_RELOAD, 32'h5);
		tk(1, 1'b1);
		chk(32'(irq_out), 32'h1);
		wr(SCTM_OFF_CLEAR, 32'h1);
		tk(5, 1'b0);
		tk(1, 1'b1);
		wr(SCTM_OFF_IRQ_EN, 32'h0);
		rd(SCTM_OFF_STATUS, 32'h3);
		chk(32'(irq_out), 32'h0);
		wr(SCTM_OFF_CTRL, 32'h0);
		wr(SCTM_OFF_CLEAR, 32'h1);
		wr(SCTM_OFF_RELOAD, 32'h2);
		card_u.rst_line(1'b0);
		wr(SCTM_OFF_CTRL, 32'h31);
		tk(4, 1'b0);
		card_u.rst_line(1'b1);
		tk(2, 1'b0);
		tk(1, 1'b1);
		chk(32'(timer0_run_enable_out), 32'h0);
		wr(SCTM_OFF_CLEAR, 32'h1);
		card_u.rst_line(1'b0);
		wr(SCTM_OFF_CTRL, 32'h31);
		card_u.rst_line(1'b1);
		tk(1, 1'b0);
		card_u.pulse(2, 1);
		tk(0, 1'b0);
		chk(32'(timer0_run_enable_out), 32'h0);
		for (int m = 5; m < 7; m++) begin
			wr(SCTM_OFF_CTRL, {24'h0, 4'(m), 4'h1});
			card_u.pulse(1, 1);
			tk(3, m == 5);
			wr(SCTM_OFF_CLEAR, 32'h1);
			tk(3, 1'b0);
			card_u.pulse(0, 1);
			tk(3, 1'b1);
			chk(32'(timer0_run_enable_out), 32'h1);
			wr(SCTM_OFF_CTRL, 32'h0);
			wr(SCTM_OFF_CLEAR, 32'h1);
		end
		wr(SCTM_OFF_IRQ_EN, 32'h1);
		wr(SCTM_OFF_CTRL, 32'h71);
		tk(3, 1'b0);
		card_u.pulse(1, 1);
		tk(2, 1'b0);
		wr(SCTM_OFF_RELOAD, 32'h3);
		card_u.pulse(0, 1);
		tk(3, 1'b0);
		tk(1, 1'b1);
		chk(32'(irq_out), 32'h1);
		wr(SCTM_OFF_CTRL, 32'h0);
		wr(SCTM_OFF_CLEAR, 32'h1);
		for (int m = 0; m < 3; m++) begin
			wr(SCTM_OFF_CTRL, {24'h0, 4'(m), 4'h1});
			card_u.pulse(1, 1);
			tk(3, 1'b0);
			card_u.pulse(0, 1);
			tk(1, m < 2);
			chk(32'(timer0_run_enable_out), 32'(m == 2));
			wr(SCTM_OFF_CTRL, 32'h0);
			wr(SCTM_OFF_CLEAR, 32'h1);
		end
		wr(SCTM_OFF_CTRL, 32'h81);
		tk(5, 1'b0);
		wr(SCTM_OFF_CTRL, 32'h0);
		rd(SCTM_OFF_RESULT, 32'h4);
		rd(SCTM_OFF_COUNT, 32'h4);
		finish_test();
	end
endmodule : testbench
